// >>> src/jspi_pkg.sv
package jspi_pkg;

    // ------------------------------------------------------------------
    // Structural limits
    // ------------------------------------------------------------------
    localparam int JSPI_MAX_W = 256;
    localparam int JSPI_MAX_INST = 128;
    localparam int JSPI_IDX_W = 7;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] JSPI_OFS_INFO = 12'h000;
    localparam logic [11:0] JSPI_OFS_CTRL = 12'h004;
    localparam logic [11:0] JSPI_OFS_STATUS = 12'h008;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int JSPI_INFO_IDX_LSB = 0;
    localparam int JSPI_INFO_PW_LSB = 8;
    localparam int JSPI_INFO_SW_LSB = 17;
    localparam int JSPI_CTRL_EN_BIT = 0;
    localparam logic [31:0] JSPI_CTRL_RST = 32'h00000001;
    localparam int JSPI_STAT_PEND_BIT = 0;
    localparam int JSPI_STAT_CNT_LSB = 8;
    localparam int JSPI_CNT_W = 8;

endpackage

// >>> src/jspi_reg_if.sv
`timescale 1ns/1ns
`default_nettype none

interface jspi_reg_if;
    import jspi_pkg::*;

    logic link_en;
    logic src_pending;
    logic [JSPI_CNT_W-1:0] upd_count;

    modport regs (
        output link_en,
        input src_pending,
        input upd_count
    );

    modport core (
        input link_en,
        output src_pending,
        output upd_count
    );

endinterface

`default_nettype wire

// >>> src/jspi_sync2.sv
`timescale 1ns/1ns
`default_nettype none

module jspi_sync2 #(
    parameter int WIDTH = 1
) (
    // Destination clock.
    input wire logic clk_i,
    // Asynchronous level in, synchronised level out.
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_i) begin
        meta <= d_i;
        q_o <= meta;
    end

endmodule

`default_nettype wire

// >>> src/jspi_apb.sv
`timescale 1ns/1ns
`default_nettype none

module jspi_apb #(
    parameter logic [31:0] INFO_WORD = 32'h00000000
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Core side.
    jspi_reg_if.regs rif
);
    import jspi_pkg::*;

    logic [31:0] ctrl;
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    wire hit_info = (paddr_i == JSPI_OFS_INFO);
    wire hit_ctrl = (paddr_i == JSPI_OFS_CTRL);
    wire hit_stat = (paddr_i == JSPI_OFS_STATUS);
    wire hit_any = hit_info | hit_ctrl | hit_stat;
    wire setup_ph = psel_i & ~penable_i;
    wire access_ph = psel_i & penable_i;
    wire wr_ctrl = access_ph & pwrite_i & hit_ctrl & pstrb_i[0];

    assign status_word = {16'h0000, rif.upd_count, 7'h00,
        rif.src_pending};
    assign next_rdata = hit_info ? INFO_WORD :
                        hit_ctrl ? ctrl :
                        hit_stat ? status_word : 32'h00000000;
    // Zero wait states; unmapped addresses answer with an error.
    assign pready_o = 1'b1;
    assign pslverr_o = access_ph & ~hit_any;
    assign rif.link_en = ctrl[JSPI_CTRL_EN_BIT];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl <= JSPI_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= {31'h00000000, pwdata_i[JSPI_CTRL_EN_BIT]};
        end
    end

    // Read data is latched in the setup cycle so it is a flop output.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h00000000;
        end else if (setup_ph) begin
            prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
        end
    end

endmodule

`default_nettype wire

// >>> src/jspi_top.sv
// How it works
// - Observed bus width is a parameter 0..256; zero removes observation.
// - Driven bus width is a separate parameter 0..256.
// - Up to 128 instances share the scan link, each addressable.
// - A build-time index selects and identifies this instance.
// - Driven bus shows a hexadecimal initial value until the first write.
// - Synchronous option registers driven data on the user clock.
// - Optional enable gates the sync registers, only with synchronous mode.
// - A read samples inputs in one cycle; a write updates in one cycle.
// - A shift chain moves driven data in and sampled data out.
// - Observed bus only samples; driven bus drives all the time.
// - Shift register per bit of the wider bus, hold register per driven bit, plus sync pair.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module jspi_top #(
    parameter int PROBE_W = 8,
    parameter int SOURCE_W = 8,
    parameter logic [6:0] INST_INDEX = 7'h00,
    parameter logic [255:0] INIT_VALUE = 256'h0,
    parameter bit SYNC_SOURCE = 1'b0,
    parameter bit USE_SRC_ENA = 1'b0
) (
    // System clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // APB register port.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Scan link from the debug hub, on the test clock.
    input wire logic tck_i,
    input wire logic tdi_i,
    input wire logic hub_sel_i,
    input wire logic [jspi_pkg::JSPI_IDX_W-1:0] hub_inst_i,
    input wire logic capture_dr_i,
    input wire logic shift_dr_i,
    input wire logic update_dr_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // User design side.
    input wire logic [(PROBE_W>0?PROBE_W:1)-1:0] probe_i,
    input wire logic source_ena_i,
    output logic [(SOURCE_W>0?SOURCE_W:1)-1:0] source_o
);
    import jspi_pkg::*;

    // ------------------------------------------------------------------
    // Derived sizes
    // ------------------------------------------------------------------
    // Zero widths keep a one-bit stub so the ports stay legal; the stub
    // is never loaded from the chain and reads as zero.
    localparam int PWE = (PROBE_W > 0) ? PROBE_W : 1;
    localparam int SWE = (SOURCE_W > 0) ? SOURCE_W : 1;
    localparam int CW = (PROBE_W > SOURCE_W) ? PROBE_W : SOURCE_W;
    localparam int CWE = (CW > 0) ? CW : 1;
    localparam bit ENA_EFF = SYNC_SOURCE & USE_SRC_ENA;
    localparam logic [SWE-1:0] SRC_INIT = INIT_VALUE[SWE-1:0];
    localparam logic [31:0] INFO_WORD =
        (32'(INST_INDEX) << JSPI_INFO_IDX_LSB) |
        (32'(PROBE_W) << JSPI_INFO_PW_LSB) |
        (32'(SOURCE_W) << JSPI_INFO_SW_LSB);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    jspi_reg_if rif ();

    jspi_apb #(
        .INFO_WORD(INFO_WORD)
    ) u_apb (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .rif(rif.regs)
    );

    // ------------------------------------------------------------------
    // Crossings into the test clock domain
    // ------------------------------------------------------------------
    logic rst_tck;
    logic en_tck;
    logic snap_req_tck;

    // The test clock must run while reset is held for the link side to
    // reach its reset state.
    jspi_sync2 #(
        .WIDTH(1)
    ) u_rst_sync (
        .clk_i(tck_i),
        .d_i(rst_i),
        .q_o(rst_tck)
    );

    jspi_sync2 #(
        .WIDTH(1)
    ) u_en_sync (
        .clk_i(tck_i),
        .d_i(rif.link_en),
        .q_o(en_tck)
    );

    // ------------------------------------------------------------------
    // Probe snapshot handshake (user clock to test clock)
    // ------------------------------------------------------------------
    // The user side samples the whole probe bus in one cycle into a
    // held word and flips a request toggle on the same edge. The link side copies the
    // word once the toggle has settled and flips an acknowledge back.
    // A new sample is only taken after the acknowledge returns, so the
    // word never moves while the other side may be reading it.
    logic [PWE-1:0] probe_snap;
    logic snap_req;
    logic snap_ack_ref;
    logic snap_ack;
    logic snap_req_seen;
    logic [PWE-1:0] probe_tck;
    wire snap_idle = (snap_req == snap_ack_ref);
    wire snap_new = (snap_req_tck != snap_req_seen);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            probe_snap <= '0;
            snap_req <= 1'b0;
        end else if (snap_idle) begin
            probe_snap <= (PROBE_W > 0) ? probe_i : '0;
            snap_req <= ~snap_req;
        end
    end

    jspi_sync2 #(
        .WIDTH(1)
    ) u_req_sync (
        .clk_i(tck_i),
        .d_i(snap_req),
        .q_o(snap_req_tck)
    );

    always_ff @(posedge tck_i) begin
        if (rst_tck) begin
            probe_tck <= '0;
            snap_req_seen <= 1'b0;
            snap_ack <= 1'b0;
        end else if (snap_new) begin
            probe_tck <= probe_snap;
            snap_req_seen <= snap_req_tck;
            snap_ack <= snap_req_tck;
        end
    end

    jspi_sync2 #(
        .WIDTH(1)
    ) u_ack_sync (
        .clk_i(ref_clk_i),
        .d_i(snap_ack),
        .q_o(snap_ack_ref)
    );

    // ------------------------------------------------------------------
    // Scan chain on the test clock
    // ------------------------------------------------------------------
    logic [CWE-1:0] shift_reg;
    logic [CWE-1:0] cap_word;
    logic [SWE-1:0] hold_reg;
    logic [SWE-1:0] upd_word;
    logic upd_tgl;

    // The hub addresses one instance at a time by its index.
    wire inst_hit = hub_sel_i & (hub_inst_i == INST_INDEX);
    wire active = inst_hit & en_tck & (CW > 0);
    wire do_cap = active & capture_dr_i;
    wire do_shift = active & shift_dr_i;
    wire do_upd = active & update_dr_i & (SOURCE_W > 0);

    genvar gi;
    generate
        for (gi = 0; gi < CWE; gi++) begin : g_cap
            if (gi < PROBE_W) begin : g_p
                assign cap_word[gi] = probe_tck[gi];
            end else begin : g_z
                assign cap_word[gi] = 1'b0;
            end
        end
        for (gi = 0; gi < SWE; gi++) begin : g_upd
            if (gi < CW) begin : g_s
                assign upd_word[gi] = shift_reg[gi];
            end else begin : g_z
                assign upd_word[gi] = 1'b0;
            end
        end
    endgenerate

    // Shifting runs least significant bit first towards the output.
    always_ff @(posedge tck_i) begin
        if (rst_tck) begin
            shift_reg <= '0;
        end else if (do_cap) begin
            shift_reg <= cap_word;
        end else if (do_shift) begin
            shift_reg <= (CWE > 1) ?
                {tdi_i, shift_reg[CWE-1:1]} : tdi_i;
        end
    end

    always_ff @(posedge tck_i) begin
        if (rst_tck) begin
            hold_reg <= SRC_INIT;
            upd_tgl <= 1'b0;
        end else if (do_upd) begin
            hold_reg <= upd_word;
            upd_tgl <= ~upd_tgl;
        end
    end

    assign tdo_o = shift_reg[0];
    assign tdo_oe_o = do_shift;

    // ------------------------------------------------------------------
    // Source drive
    // ------------------------------------------------------------------
    logic upd_tgl_ref;
    logic upd_seen;
    logic src_pending;
    logic [SWE-1:0] src_sync;
    logic [JSPI_CNT_W-1:0] upd_count;
    wire upd_new = (upd_tgl_ref != upd_seen);
    wire src_go = (src_pending | upd_new) &
                  (~ENA_EFF | source_ena_i);

    jspi_sync2 #(
        .WIDTH(1)
    ) u_upd_sync (
        .clk_i(ref_clk_i),
        .d_i(upd_tgl),
        .q_o(upd_tgl_ref)
    );

    // The hold word is stable from the update until the next update, so
    // it is read here only after its toggle has passed two flops. Two
    // updates closer than about four user clocks would race; the host
    // link is far slower than that.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            upd_seen <= 1'b0;
            src_pending <= 1'b0;
            src_sync <= SRC_INIT;
            upd_count <= '0;
        end else begin
            upd_seen <= upd_tgl_ref;
            if (src_go) begin
                src_sync <= hold_reg;
                src_pending <= 1'b0;
                upd_count <= upd_count + 1'b1;
            end else if (upd_new) begin
                src_pending <= 1'b1;
            end
        end
    end

    // Without the synchronous option the hold register drives directly.
    generate
        if (SOURCE_W == 0) begin : g_nosrc
            assign source_o = '0;
        end else if (SYNC_SOURCE) begin : g_sync
            assign source_o = src_sync;
        end else begin : g_direct
            assign source_o = hold_reg;
        end
    endgenerate

    assign rif.src_pending = src_pending;
    assign rif.upd_count = upd_count;

endmodule

`default_nettype wire

// >>> verif/jspi_top_sva.sv
`timescale 1ns/1ns
`default_nettype none

module jspi_top_sva #(
    parameter int PROBE_W = 8,
    parameter int SOURCE_W = 8,
    parameter logic [6:0] INST_INDEX = 7'h00,
    parameter logic [255:0] INIT_VALUE = 256'h0
) (
    // Register side.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Scan link and user side.
    input wire logic tck_i,
    input wire logic tdi_i,
    input wire logic hub_sel_i,
    input wire logic [jspi_pkg::JSPI_IDX_W-1:0] hub_inst_i,
    input wire logic capture_dr_i,
    input wire logic shift_dr_i,
    input wire logic update_dr_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic [(PROBE_W>0?PROBE_W:1)-1:0] probe_i,
    input wire logic [(SOURCE_W>0?SOURCE_W:1)-1:0] source_o
);
    localparam int SW = SOURCE_W > 0 ? SOURCE_W : 1;
    localparam logic [31:0] INFO = {6'h00, 9'(SOURCE_W), 9'(PROBE_W),
        1'b0, INST_INDEX};
    wire logic sel_w = hub_sel_i && hub_inst_i == INST_INDEX;

    // ----
    // Steps of one data scan
    // ----
    sequence cap_s;
        sel_w && capture_dr_i;
    endsequence
    sequence shift_s;
        tdo_oe_o && !capture_dr_i;
    endsequence

    ready_const_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        psel_i && penable_i |-> pready_o) else $error("no ready");
    slverr_map_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        psel_i && penable_i |->
        pslverr_o == !(paddr_i inside {12'h000, 12'h004, 12'h008}))
        else $error("bad error response");
    info_read_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        psel_i && !penable_i && !pwrite_i && paddr_i == 12'h000 |=>
        prdata_o == INFO) else $error("bad info word");
    init_drive_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $fell(rst_i) |-> source_o == INIT_VALUE[SW-1:0])
        else $error("bad initial drive");
    oe_select_a: assert property (
        @(posedge tck_i) disable iff (rst_i)
        tdo_oe_o |-> sel_w && shift_dr_i) else $error("stray enable");
    quiet_other_a: assert property (
        @(posedge tck_i) disable iff (rst_i)
        !sel_w |=> $stable(tdo_o) && $stable(source_o))
        else $error("unselected change");
    first_bit_a: assert property (
        @(posedge tck_i) disable iff (rst_i)
        cap_s ##1 shift_s |-> tdo_o == probe_i[0])
        else $error("bad first bit");
    second_bit_a: assert property (
        @(posedge tck_i) disable iff (rst_i)
        cap_s ##1 shift_s ##1 shift_s |-> tdo_o == probe_i[1])
        else $error("bad second bit");
    // Holds only when the chain is as long as the driven bus.
    update_last_a: assert property (
        @(posedge tck_i) disable iff (rst_i)
        shift_s ##1 (sel_w && update_dr_i) |=>
        source_o[SW-1] == $past(tdi_i, 2)) else $error("bad update");
endmodule

bind jspi_top jspi_top_sva #(.PROBE_W(PROBE_W), .SOURCE_W(SOURCE_W),
    .INST_INDEX(INST_INDEX), .INIT_VALUE(INIT_VALUE)) u_sva (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tck_i(tck_i), .tdi_i(tdi_i), .hub_sel_i(hub_sel_i),
    .hub_inst_i(hub_inst_i), .capture_dr_i(capture_dr_i),
    .shift_dr_i(shift_dr_i), .update_dr_i(update_dr_i), .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o), .probe_i(probe_i), .source_o(source_o));

`default_nettype wire

// >>> verif/jspi_hub_model.sv
`timescale 1ns/1ns
`default_nettype none

module jspi_hub_model #(
    parameter int N = 8
) (
    // Link towards the instrument.
    output logic tck_o,
    output logic tdi_o,
    output logic hub_sel_o,
    output logic [jspi_pkg::JSPI_IDX_W-1:0] hub_inst_o,
    output logic capture_dr_o,
    output logic shift_dr_o,
    output logic update_dr_o,
    input wire logic tdo_i
);
    initial begin
        tck_o = 1'b0;
        hub_inst_o = '0;
        {hub_sel_o, capture_dr_o, shift_dr_o, update_dr_o, tdi_o} = 5'h00;
    end

    // The link clock runs only while a task is busy; levels change just
    // after a rise and are held until the next one.
    task automatic step(input logic [6:0] inst, input logic [4:0] lv);
        tck_o = 1'b1;
        #1;
        hub_inst_o = inst;
        {hub_sel_o, capture_dr_o, shift_dr_o, update_dr_o, tdi_o} = lv;
        #79;
        tck_o = 1'b0;
        #80;
    endtask

    // A released data line toggles so that no stale bit reads as good.
    task automatic idle(input int n);
        repeat (n) step(hub_inst_o, {4'h0, ~tdi_o});
    endtask

    task automatic scan(input logic [6:0] inst, input logic [N-1:0] din,
                        input int gap, output logic [N-1:0] dout);
        step(inst, {4'hC, ~tdi_o});
        repeat (gap) step(inst, {4'h8, ~tdi_o});
        for (int k = 0; k < N; k++) begin
            step(inst, {4'hA, din[k]});
            dout[k] = tdo_i;
        end
        step(inst, {4'h9, ~tdi_o});
        idle(1);
    endtask
endmodule

`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define chk(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, g, e); \
    end \
end

module tb;
    localparam logic [6:0] IDX = 7'h05;
    localparam logic [255:0] INIT = 256'hA5;
    localparam logic [31:0] INFO = {6'h00, 9'h008, 9'h008, 1'b0, IDX};
    localparam logic [32:0] RD [4] = '{{1'b0, INFO}, 33'h1, 33'h0,
        33'h100000000};
    logic ref_clk_i, rst_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic pready_o, pslverr_o, tdo_o, tdo_oe_o, source_ena_i;
    logic [3:0] pstrb_i;
    logic [7:0] probe_i, source_o, dout, din, last, seen, e8;
    logic [32:0] e33;
    logic [32:0] exp_q[$];
    logic [7:0] src_q[$];
    wire logic tck, tdi, hsel, cap, sh, upd;
    wire logic [6:0] hinst;
    int num_errors = 0;
    int n_compared = 0;
    bit armed = 1'b0;

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    jspi_top #(.PROBE_W(8), .SOURCE_W(8), .INST_INDEX(IDX),
        .INIT_VALUE(INIT)) uut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .tck_i(tck),
        .tdi_i(tdi), .hub_sel_i(hsel), .hub_inst_i(hinst),
        .capture_dr_i(cap), .shift_dr_i(sh), .update_dr_i(upd),
        .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .probe_i(probe_i),
        .source_ena_i(source_ena_i), .source_o(source_o));

    jspi_hub_model #(.N(8)) hub (.tck_o(tck), .tdi_o(tdi), .hub_sel_o(hsel),
        .hub_inst_o(hinst), .capture_dr_o(cap), .shift_dr_o(sh),
        .update_dr_o(upd), .tdo_i(tdo_o));

    task automatic tally_and_finish();
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        if (!w) begin
            exp_q.push_back(e);
        end
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= 4'h1 | 4'($urandom());
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    always @(posedge ref_clk_i) begin
        if (psel_i && penable_i && pready_o && !pwrite_i) begin
            e33 = exp_q.pop_front();
            `chk({pslverr_o, prdata_o}, e33)
        end
        if (armed && source_o !== seen) begin
            e8 = src_q.size() > 0 ? src_q.pop_front() : ~source_o;
            `chk(source_o, e8)
            seen = source_o;
        end
    end

    // ----
    // Stimulus
    // ----
    initial begin
        {rst_i, psel_i, penable_i, pwrite_i} = 4'h8;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        pstrb_i = 4'h0;
        source_ena_i = 1'b0;
        probe_i = 8'h00;
        void'($urandom(32'hB520));
        #3;
        // The link side needs a few of its own edges inside reset.
        fork
            repeat (4) @(posedge ref_clk_i);
            hub.idle(3);
        join
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        hub.idle(3);
        `chk(source_o, INIT[7:0])
        seen = INIT[7:0];
        last = INIT[7:0];
        armed = 1'b1;
        apb(1'b1, 12'h000, 32'hFFFFFFFF, '0);
        apb(1'b1, 12'h008, 32'hFFFFFFFF, '0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0, RD[i]);
        end
        apb(1'b1, 12'h004, 32'h0, '0);
        hub.idle(3);
        hub.scan(IDX, 8'h3C, 0, dout);
        `chk(dout, 8'h00)
        apb(1'b1, 12'h004, 32'h1, '0);
        hub.idle(3);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_i);
            probe_i <= 8'($urandom());
            source_ena_i <= 1'($urandom());
            din = last ^ (8'($urandom()) | 8'h01);
            hub.idle(4);
            src_q.push_back(din);
            hub.scan(IDX, din, 3 * (i % 2), dout);
            `chk(dout, probe_i)
            last = din;
        end
        hub.scan(IDX ^ 7'h01, ~last, 0, dout);
        `chk(dout, {8{last[0]}})
        repeat (8) @(posedge ref_clk_i);
        apb(1'b0, 12'h008, 32'h0, 33'h400);
        @(posedge ref_clk_i);
        `chk(exp_q.size() + src_q.size(), 0)
        tally_and_finish();
    end

    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
